// file: eafob_cfg.svh
// Purpose: constants of the extended-address four-output bank block
// Assumes: 25 MHz clock; times are given in their own unit, cycles derived
// Notes: definitions only
//
// Overview of operation
// R1: In extended address mode, I3 selects the A or B slave at one address.
// R2: Extended mode without four-output option uses only I0..I2 as output data.
// R3: Extended mode replies still carry four input data bits.
// R4: Four-output mode uses I2 to pick bank D0/D1 or bank D2/D3.
// R5: Master alternates I2 from call to call to feed both banks.
// R6: An output event updates the data pins and pulses the data strobe.
// R7: Parallel update raises output events only on calls with I2 low.
// R8: Without parallel update every call refreshes one bank, the other holds.
// R9: Parallel update with I2 high stores I0/I1 in hold bits, outputs unchanged.
// R10: Parallel update with I2 low drives I0/I1 to D2/D3 and hold bits to D0/D1.
// R11: Bank watchdog runs only when all its enabling conditions hold.
// R12: Missing I2 alternation beyond timeout pulses data and parameter strobes.
// R13: After those strobes: block data port, rerun init, outputs inactive.
// R14: Four-output mode samples and returns inputs on every call regardless of I2.
// R15: Data strobe pin held low externally long enough resets and reloads config.
// R16: Data port stays inactive until a parameter write clears the block flag.
// R17: Each I2 change restarts the watchdog timer; disabled conditions clear it.
`ifndef EAFOB_CFG_SVH
`define EAFOB_CFG_SVH
`define EAFOB_CLK_KHZ 25000
`define EAFOB_WDOG_NOM_MS 327
`define EAFOB_WDOG_TOL_MS 16
`define EAFOB_WDOG_CYC ((`EAFOB_WDOG_NOM_MS + `EAFOB_WDOG_TOL_MS) * `EAFOB_CLK_KHZ)
`define EAFOB_STB_NS 1000
`define EAFOB_STB_CYC ((`EAFOB_STB_NS * `EAFOB_CLK_KHZ + 999999) / 1000000)
`define EAFOB_XRST_NS 10000
`define EAFOB_XRST_CYC ((`EAFOB_XRST_NS * `EAFOB_CLK_KHZ + 999999) / 1000000)
`define EAFOB_SEL_BANK_BIT 2
`define EAFOB_SEL_AB_BIT 3
`define EAFOB_DOUT_RST 4'h0
`define EAFOB_HOLD_RST 2'h0
`define EAFOB_BLOCK_RST 1'b1
`endif

// file: eafob_pkg.sv
// Purpose: types of the extended-address four-output bank block
// Assumes: constants live in eafob_cfg.svh
// Notes: no imports; users write eafob_pkg::name
package eafob_pkg;
  // One received master data call
  typedef struct packed {
    logic valid;
    logic [3:0] info;
  } eafob_call_t;
  // Mode straps seen by the bank logic
  typedef struct packed {
    logic ext_addr_mode;
    logic four_out_bank_enable;
    logic parallel_bank_update;
  } eafob_mode_t;
  // Watchdog sequencing
  typedef enum logic [1:0] {
    EAFOB_WD_RUN = 2'b00,
    EAFOB_WD_STROBE = 2'b01,
    EAFOB_WD_RESET = 2'b10
  } eafob_wd_state_t;
endpackage

// file: eafob_banks.sv
// Purpose: output banks, bank watchdog and strobe-pin reset of a field-bus slave
// Assumes: calls arrive decoded on this clock; pins pass a two-stage synchroniser
// Notes: strobe pins are open drain, active low; oe high means driving low
`timescale 1ns/1ps
`default_nettype none
`include "eafob_cfg.svh"
module eafob_banks #(
  parameter int WDOG_CYC = `EAFOB_WDOG_CYC,
  parameter int STB_CYC = `EAFOB_STB_CYC,
  parameter int XRST_CYC = `EAFOB_XRST_CYC
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic clk_en,
  input wire eafob_pkg::eafob_call_t call,
  input wire logic param_write_call,
  input wire eafob_pkg::eafob_mode_t mode,
  input wire logic [4:0] slave_addr,
  input wire logic comm_wdog_active,
  input wire logic nvm_write_busy,
  input wire logic [3:0] input_pins,
  input wire logic data_strobe_n_pin_in,
  output logic data_strobe_n_pin_out,
  output logic data_strobe_n_pin_oe,
  output logic param_strobe_n_pin_out,
  output logic param_strobe_n_pin_oe,
  output logic data_out_bit0,
  output logic data_out_bit1,
  output logic data_out_bit2,
  output logic data_out_bit3,
  output logic [3:0] reply_data,
  output logic reply_valid,
  output logic port_exchange_block,
  output logic init_request
);
  // Elaboration check: counter widths are 24 bits (watchdog), 8 bits (strobes) and 16 bits (pin reset)
  generate
    if (WDOG_CYC < 2 || WDOG_CYC > 16777215 || STB_CYC < 1 || STB_CYC > 255 ||
        XRST_CYC < 1 || XRST_CYC > 65535) begin : g_bad_param
      $error("eafob_banks: timing parameter out of range");
    end
  endgenerate

  logic [3:0] dout_ff, in_s1_ff, in_s2_ff, reply_data_ff;
  logic reply_valid_ff, block_ff, last_sel_ff, init_ff;
  logic dpin_s1_ff, dpin_s2_ff;
  logic [1:0] oe_dly_ff, hold_ff;
  logic [23:0] wd_cnt_ff;
  logic [7:0] dstb_cnt_ff, pstb_cnt_ff;
  logic [15:0] xrst_cnt_ff;
  eafob_pkg::eafob_wd_state_t wd_state_ff;

  // Call decoding
  wire call_seen = clk_en & call.valid;
  wire sel_bank = call.info[`EAFOB_SEL_BANK_BIT];
  wire four_mode = mode.ext_addr_mode & mode.four_out_bank_enable; // [R4]
  wire wd_idle = (wd_state_ff == eafob_pkg::EAFOB_WD_RUN);
  wire call_ok = call_seen & ~block_ff & wd_idle; // [R16]
  wire hold_load = call_ok & four_mode & mode.parallel_bank_update & sel_bank; // [R9]
  wire out_event = call_ok & ~hold_load; // [R7] [R8]

  // Next output image per mode; I3 is never data in extended mode
  wire [3:0] low_call = {call.info[1:0],
                         mode.parallel_bank_update ? hold_ff : dout_ff[1:0]}; // [R10]
  wire [3:0] high_call = {dout_ff[3:2], call.info[1:0]}; // [R8]
  wire [3:0] four_next = sel_bank ? high_call : low_call; // [R4]
  wire [3:0] ext_next = {dout_ff[3], call.info[2:0]}; // [R1] [R2]
  wire [3:0] nxt_dout = four_mode ? four_next :
                        mode.ext_addr_mode ? ext_next : call.info;

  // Watchdog enable and alternation detection
  wire wd_enable = comm_wdog_active & four_mode & (slave_addr != 5'h00) &
                   ~nvm_write_busy & ~block_ff; // [R11]
  wire sel_toggle = call_seen & (sel_bank != last_sel_ff); // [R17]
  wire wd_timeout = wd_idle & wd_enable & (wd_cnt_ff == 24'(WDOG_CYC)); // [R12]
  wire strobes_done = (dstb_cnt_ff == 8'h00) & (pstb_cnt_ff == 8'h00);
  wire wd_reset = (wd_state_ff == eafob_pkg::EAFOB_WD_RESET);

  // External reset sensed only once our own drive has long gone from the sync
  wire pin_free = ~data_strobe_n_pin_oe & (oe_dly_ff == 2'b00);
  wire xrst_fire = pin_free & ~dpin_s2_ff & (xrst_cnt_ff == 16'(XRST_CYC - 1)); // [R15]
  // Gated by the enable so that a frozen block keeps every flop
  wire full_reset = clk_en & (wd_reset | xrst_fire); // [R13] [R15]

  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge clock) begin
    if (reset) begin
      in_s1_ff <= 4'h0;
      in_s2_ff <= 4'h0;
      dpin_s1_ff <= 1'b1;
      dpin_s2_ff <= 1'b1;
      oe_dly_ff <= 2'b00;
    end else if (clk_en) begin
      in_s1_ff <= input_pins;
      in_s2_ff <= in_s1_ff;
      dpin_s1_ff <= data_strobe_n_pin_in;
      dpin_s2_ff <= dpin_s1_ff;
      oe_dly_ff <= {oe_dly_ff[0], data_strobe_n_pin_oe};
    end
  end

  // Reply carries four sampled inputs on every call, whatever I2 is
  always_ff @(posedge clock) begin
    if (reset) begin
      reply_data_ff <= 4'h0;
      reply_valid_ff <= 1'b0;
    end else if (clk_en) begin
      reply_valid_ff <= call.valid; // [R3] [R14]
      if (call.valid) begin
        reply_data_ff <= in_s2_ff; // [R3] [R14]
      end
    end
  end

  // Data outputs and hold bits
  always_ff @(posedge clock) begin
    if (reset) begin
      dout_ff <= `EAFOB_DOUT_RST;
      hold_ff <= `EAFOB_HOLD_RST;
      last_sel_ff <= 1'b0;
    end else if (full_reset) begin
      dout_ff <= `EAFOB_DOUT_RST; // [R13]
      hold_ff <= `EAFOB_HOLD_RST;
    end else if (clk_en) begin
      if (out_event) begin
        dout_ff <= nxt_dout; // [R6]
      end
      if (hold_load) begin
        hold_ff <= call.info[1:0]; // [R9]
      end
      if (call.valid) begin
        last_sel_ff <= sel_bank;
      end
    end
  end

  // Block flag: set by any internal reset, cleared by a parameter write; set wins
  always_ff @(posedge clock) begin
    if (reset) begin
      block_ff <= `EAFOB_BLOCK_RST;
      init_ff <= 1'b0;
    end else if (clk_en) begin
      init_ff <= full_reset; // [R13] [R15]
      if (full_reset) begin
        block_ff <= 1'b1; // [R13]
      end else if (clk_en && param_write_call) begin
        block_ff <= 1'b0; // [R16]
      end
    end
  end

  // Watchdog timer; restart on alternation, clear while disabled
  always_ff @(posedge clock) begin
    if (reset) begin
      wd_cnt_ff <= 24'h000000;
      wd_state_ff <= eafob_pkg::EAFOB_WD_RUN;
    end else if (clk_en) begin
      if (!wd_enable || sel_toggle || !wd_idle) begin
        wd_cnt_ff <= 24'h000000; // [R17]
      end else if (!wd_timeout) begin
        wd_cnt_ff <= wd_cnt_ff + 24'h000001;
      end
      case (wd_state_ff)
        eafob_pkg::EAFOB_WD_RUN: begin
          if (wd_timeout) begin
            wd_state_ff <= eafob_pkg::EAFOB_WD_STROBE; // [R12]
          end
        end
        eafob_pkg::EAFOB_WD_STROBE: begin
          if (strobes_done) begin
            wd_state_ff <= eafob_pkg::EAFOB_WD_RESET; // [R13]
          end
        end
        eafob_pkg::EAFOB_WD_RESET: wd_state_ff <= eafob_pkg::EAFOB_WD_RUN;
        default: wd_state_ff <= eafob_pkg::EAFOB_WD_RUN;
      endcase
    end
  end

  // Strobe pulse widths; a timeout fires both strobes together
  always_ff @(posedge clock) begin
    if (reset) begin
      dstb_cnt_ff <= 8'h00;
      pstb_cnt_ff <= 8'h00;
    end else if (clk_en) begin
      if (out_event || wd_timeout) begin
        dstb_cnt_ff <= 8'(STB_CYC); // [R6] [R12]
      end else if (dstb_cnt_ff != 8'h00) begin
        dstb_cnt_ff <= dstb_cnt_ff - 8'h01;
      end
      if (param_write_call || wd_timeout) begin
        pstb_cnt_ff <= 8'(STB_CYC); // [R12]
      end else if (pstb_cnt_ff != 8'h00) begin
        pstb_cnt_ff <= pstb_cnt_ff - 8'h01;
      end
    end
  end

  // Low-time counter on the shared strobe pin
  always_ff @(posedge clock) begin
    if (reset) begin
      xrst_cnt_ff <= 16'h0000;
    end else if (clk_en) begin
      if (!pin_free || dpin_s2_ff || xrst_fire) begin
        xrst_cnt_ff <= 16'h0000;
      end else begin
        xrst_cnt_ff <= xrst_cnt_ff + 16'h0001; // [R15]
      end
    end
  end

  // Output drive
  assign data_strobe_n_pin_oe = (dstb_cnt_ff != 8'h00);
  assign data_strobe_n_pin_out = 1'b0;
  assign param_strobe_n_pin_oe = (pstb_cnt_ff != 8'h00);
  assign param_strobe_n_pin_out = 1'b0;
  assign data_out_bit0 = dout_ff[0];
  assign data_out_bit1 = dout_ff[1];
  assign data_out_bit2 = dout_ff[2];
  assign data_out_bit3 = dout_ff[3];
  assign reply_data = reply_data_ff;
  assign reply_valid = reply_valid_ff;
  assign port_exchange_block = block_ff;
  assign init_request = init_ff;

  // Checks
  sequence s_outputs_hold;
    ##1 $stable(dout_ff);
  endsequence
  sequence s_both_strobes;
    ##1 (data_strobe_n_pin_oe && param_strobe_n_pin_oe);
  endsequence
  property p_par_hold;
    @(posedge clock) disable iff (reset)
      hold_load |-> s_outputs_hold ##0 (hold_ff[1:0] == $past(call.info[1:0]));
  endproperty
  a_par_hold: assert property (p_par_hold) else $error("hold call moved outputs"); // [R9]
  property p_par_low;
    @(posedge clock) disable iff (reset)
      (out_event && four_mode && mode.parallel_bank_update && !full_reset) |=>
        (dout_ff == {$past(call.info[1:0]), $past(hold_ff[1:0])});
  endproperty
  a_par_low: assert property (p_par_low) else $error("parallel update wrong"); // [R10]
  property p_bank_split;
    @(posedge clock) disable iff (reset)
      (out_event && four_mode && !mode.parallel_bank_update && !sel_bank && !full_reset)
        |=> (dout_ff[1:0] == $past(dout_ff[1:0])) && (dout_ff[3:2] == $past(call.info[1:0]));
  endproperty
  a_bank_split: assert property (p_bank_split) else $error("bank 2 refresh wrong"); // [R8]
  property p_ext_three;
    @(posedge clock) disable iff (reset)
      (out_event && mode.ext_addr_mode && !four_mode && !full_reset) |=>
        (dout_ff[3] == $past(dout_ff[3])) && (dout_ff[2:0] == $past(call.info[2:0]));
  endproperty
  a_ext_three: assert property (p_ext_three) else $error("ext mode used I3"); // [R2]
  property p_event_strobe;
    @(posedge clock) disable iff (reset)
      out_event |=> data_strobe_n_pin_oe;
  endproperty
  a_event_strobe: assert property (p_event_strobe) else $error("no data strobe"); // [R6]
  property p_reply;
    @(posedge clock) disable iff (reset)
      call_seen |=> reply_valid && (reply_data == $past(in_s2_ff));
  endproperty
  a_reply: assert property (p_reply) else $error("reply missing"); // [R14]
  property p_timeout;
    @(posedge clock) disable iff (reset)
      (clk_en && wd_timeout) |-> s_both_strobes;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout strobes missing"); // [R12]
  property p_wd_reset;
    @(posedge clock) disable iff (reset)
      (clk_en && wd_reset) |=> port_exchange_block && (dout_ff == 4'h0) && init_request;
  endproperty
  a_wd_reset: assert property (p_wd_reset) else $error("watchdog reset incomplete"); // [R13]
  property p_blocked;
    @(posedge clock) disable iff (reset)
      (block_ff && !full_reset) |=> $stable(dout_ff);
  endproperty
  a_blocked: assert property (p_blocked) else $error("outputs moved while blocked"); // [R16]
  property p_wd_clear;
    @(posedge clock) disable iff (reset)
      (clk_en && !wd_enable) |=> (wd_cnt_ff == 24'h000000);
  endproperty
  a_wd_clear: assert property (p_wd_clear) else $error("timer ran while disabled"); // [R11]
endmodule
`default_nettype wire

// file: eafob_master_model.sv
// Purpose: field-bus master and strobe pin partner of the bank block
// Assumes: calls arrive as decoded one-cycle pulses on the block clock
// Notes: strobe pin has a pull-up; any oe high sinks it
`timescale 1ns/1ps
`default_nettype none
module eafob_master_model (
  input wire logic clock,
  input wire logic dstb_oe,
  input wire logic pull_low,
  output var eafob_pkg::eafob_call_t call,
  output logic param_write_call,
  output logic dstb_pin
);
  // Open drain wire, external pull-down doubles as reset request
  assign dstb_pin = ~(dstb_oe | pull_low);
  initial begin
    call = '0;
    param_write_call = 1'b0;
  end
  // One call pulse; info scrambled once no longer valid
  task automatic send_call(input logic [3:0] info);
    @(posedge clock);
    #2;
    call.valid = 1'b1;
    call.info = info;
    @(posedge clock);
    #2;
    call.valid = 1'b0;
    call.info = ~info;
  endtask
  // Parameter write, the only way to open the data port
  task automatic send_wpar();
    @(posedge clock);
    #2;
    param_write_call = 1'b1;
    @(posedge clock);
    #2;
    param_write_call = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: eafob_banks_tb_top.sv
// Purpose: self-checking bench of the four-output bank block
// Assumes: shortened watchdog, strobe and pin reset counts
// Notes: caller notes expectations, watcher pops them on each reply
`timescale 1ns/1ps
`default_nettype none
module eafob_banks_tb_top;
  typedef struct packed {logic [3:0] d; logic [3:0] r; logic stb;} eafob_note_t;
  logic clock, reset, pwc, dpin, doe, poe, d0, d1, d2, d3, rv, blk_o, init_o, pull_low;
  logic comm, nvm, blk, st, dpo, ppo, ce;
  logic [4:0] addr;
  logic [3:0] pins, rd, exp_d, nd;
  logic [1:0] hold;
  eafob_pkg::eafob_call_t call;
  eafob_pkg::eafob_mode_t mode;
  eafob_note_t notes[$];
  integer seed = 6109, bad_count = 0, n_checks = 0, cyc = 0, i, n;
  wire [3:0] dout = {d3, d2, d1, d0};
  eafob_banks #(.WDOG_CYC(50), .STB_CYC(4), .XRST_CYC(6)) i_dut (.clock(clock), .reset(reset),
    .clk_en(ce), .call(call), .param_write_call(pwc), .mode(mode), .slave_addr(addr),
    .comm_wdog_active(comm), .nvm_write_busy(nvm), .input_pins(pins),
    .data_strobe_n_pin_in(dpin), .data_strobe_n_pin_out(dpo), .data_strobe_n_pin_oe(doe),
    .param_strobe_n_pin_out(ppo), .param_strobe_n_pin_oe(poe), .data_out_bit0(d0),
    .data_out_bit1(d1), .data_out_bit2(d2), .data_out_bit3(d3), .reply_data(rd),
    .reply_valid(rv), .port_exchange_block(blk_o), .init_request(init_o));
  eafob_master_model i_master (.clock(clock), .dstb_oe(doe), .pull_low(pull_low),
    .call(call), .param_write_call(pwc), .dstb_pin(dpin));
  // Free-running 25 MHz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick(input integer k);
    repeat (k) @(posedge clock);
    #2;
  endtask
  // Expected bank update for one call, then the call itself
  task automatic do_call(input logic [3:0] info);
    pins = 4'($random(seed));
    tick(3);
    nd = exp_d;
    st = 1'b0;
    if (blk) st = 1'b0;
    else if (!mode.ext_addr_mode) {nd, st} = {info, 1'b1};
    else if (!mode.four_out_bank_enable) {nd[2:0], st} = {info[2:0], 1'b1};
    else if (!info[2]) begin
      nd[3:2] = info[1:0];
      if (mode.parallel_bank_update) nd[1:0] = hold;
      st = 1'b1;
    end
    else if (!mode.parallel_bank_update) {nd[1:0], st} = {info[1:0], 1'b1};
    else hold = info[1:0];
    notes.push_back({nd, pins, st});
    exp_d = nd;
    i_master.send_call(info);
    tick(4);
  endtask
  // Watcher: each reply matched against the oldest note
  always @(posedge clock) begin
    #1;
    if (rv === 1'b1) begin
      if (notes.size() == 0) chk(9'h1FF, 9'h000);
      else chk({dout, rd, doe}, notes.pop_front());
    end
  end
  // Hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    ce = 1'b1;
    {reset, comm, nvm, pull_low, blk, hold, exp_d} = 11'h440;
    {pins, addr, mode} = 12'h0A6;
    tick(4);
    reset = 1'b0;
    do_call(4'h3);
    i_master.send_wpar();
    chk({7'h00, blk_o, poe}, 9'h001);
    blk = 1'b0;
    // Every mode, alternating I2 from 1
    for (n = 0; n < 4; n++) begin
      mode = (n == 0) ? 3'b000 : (n == 1) ? 3'b100 : (n == 2) ? 3'b110 : 3'b111;
      for (i = 0; i < 4; i++) do_call({1'($random(seed)), ~i[0], 2'($random(seed))});
    end
    // Clock enable low: a call is ignored and nothing moves
    ce = 1'b0;
    i_master.send_call(4'h5);
    tick(2);
    chk({dout, 4'h0, rv}, {exp_d, 5'h00});
    ce = 1'b1;
    // Alternation keeps the bank watchdog quiet
    mode = 3'b110;
    comm = 1'b1;
    for (i = 0; i < 12; i++) do_call({1'b0, i[0], 2'($random(seed))});
    chk({7'h00, blk_o, init_o}, 9'h000);
    nvm = 1'b1;
    tick(80);
    chk({8'h00, blk_o}, 9'h000);
    nvm = 1'b0;
    // Silence: strobes, then forced reset
    n = 0;
    while (!(doe && poe) && n < 200) begin tick(1); n++; end
    chk({5'h00, doe, poe, dpo, ppo}, 9'h00C);
    n = 0;
    while (init_o !== 1'b1 && n < 40) begin tick(1); n++; end
    chk({4'h0, blk_o, dout}, 9'h010);
    {blk, exp_d, comm} = 6'h20;
    // Strobe pin held low from outside
    i_master.send_wpar();
    tick(8);
    pull_low = 1'b1;
    n = 0;
    while (init_o !== 1'b1 && n < 30) begin tick(1); n++; end
    pull_low = 1'b0;
    chk({7'h00, blk_o, init_o}, 9'h003);
    tick(4);
    chk(9'(notes.size()), 9'h000);
    final_report();
  end
endmodule
`default_nettype wire
